//--- hdl/dsa_cfg.svh
// offsets, field positions, codes and reset values of the dual sub/add slice
//
// Overview of operation
// - dual mode splits unit and accumulator into 16-bit low, 24-bit high path
// - temporary feeds low path as is, widened copy feeds high path
// - 32-bit operand: low word to low path, widened high word to high path
// - pair fetch: high word at address, low word at address xor one
// - overflow checked per path; either one sets the accumulator flag
// - low path overflow at bit 15, high path overflow at bit 31
// - carry status takes high path carry at bit 31; low carry never shown
// - saturation clamps low path to 7fff or 8000 on its overflow
// - saturation clamps high path to 00_7fff or ff_8000 on its overflow
// - legacy mode disables saturation and reports only high path overflow
// - dual subtract, legacy with split: no carry across bit 15
// - dual subtract, legacy without split: carry crosses bit 15
// - subtract-add ignores split; uses legacy, saturation, extension bits only
// - dual subtract: high = high word - temp, low = low word - temp
// - 16-bit form: word feeds both paths; high = word - t, low = word + t
// - 32-bit form: high = high word - t, low = low word + t
// - three-byte instructions, one cycle each, never paired
// - decode: de with nibble 1001 short form, ee with nibble 111x long form
// - repeat allowed; flags and saturation evaluated every iteration
`ifndef DSA_CFG_SVH
`define DSA_CFG_SVH

`define DSA_OFF_CTRL    8'h00
`define DSA_OFF_STATUS  8'h04
`define DSA_OFF_INSTR   8'h08
`define DSA_OFF_REPEAT  8'h0c
`define DSA_REG_TREG    4'h1
`define DSA_REG_ACC     3'h1
`define DSA_REG_DMEM    2'h1

`define DSA_C_SXM       0
`define DSA_C_SAT       1
`define DSA_C_LEG       2
`define DSA_C_SPLIT     3
`define DSA_S_CARRY     4
`define DSA_S_BUSY      5
`define DSA_S_BAD       6

`define DSA_INSTR_W     24
`define DSA_F_OPC       16
`define DSA_F_ADDR      9
`define DSA_F_SS        6
`define DSA_F_DD        4
`define DSA_F_NIB       0
`define DSA_OPC_SHORT   8'hde
`define DSA_OPC_LONG    8'hee
`define DSA_NIB_SA16    4'h9
`define DSA_NIB_SA32    3'h7
`define DSA_NIB_DSUB    4'hc

`define DSA_LO_MAX      16'h7fff
`define DSA_LO_MIN      16'h8000
`define DSA_HI_MAX      24'h00_7fff
`define DSA_HI_MIN      24'hff_8000
`define DSA_CTRL_RST    4'h0
`define DSA_RPT_RST     8'h00

`endif

//--- hdl/dsa_pkg.sv
// types shared by the dual sub/add slice
package dsa_pkg;
  typedef enum logic [1:0] {op_bad, op_sa16, op_sa32, op_dsub} dsa_op_t;
  typedef enum logic {st_idle, st_run} dsa_state_t;
  typedef logic [39:0] dsa_acc_t;
endpackage : dsa_pkg

//--- hdl/dsa_lane.sv
// one add/subtract lane with overflow, carry and saturation at bit p
`timescale 1ns/100ps
module dsa_lane #(
  parameter int W = 16,
  parameter int P = 15
) (
  // operands
  input  wire logic [W-1:0] i_a,
  input  wire logic [W-1:0] i_b,
  input  wire logic         i_sub,
  input  wire logic         i_cin,
  // controls
  input  wire logic         i_sat_en,
  input  wire logic         i_ovf_en,
  // results
  output logic [W-1:0]      o_res,
  output logic              o_cout,
  output logic              o_ovf
);
  localparam logic [W-1:0] MAXV = {{(W-P){1'b0}}, {P{1'b1}}};
  localparam logic [W-1:0] MINV = {{(W-P){1'b1}}, {P{1'b0}}};

  logic [W-1:0] bop;
  logic [W:0]   ext;
  logic [P+1:0] low;

  assign bop = i_sub ? ~i_b : i_b;
  assign ext = {i_a[W-1], i_a} + {bop[W-1], bop} + {{W{1'b0}}, i_cin};
  // carry taken at bit p, not at the lane top
  assign low = {1'b0, i_a[P:0]} + {1'b0, bop[P:0]} + {{(P+1){1'b0}}, i_cin};
  assign o_cout = low[P+1];
  // overflow when bit p and the bits above it disagree with the true sign
  assign o_ovf = i_ovf_en && (ext[W:P] != {(W-P+1){ext[W]}});
  assign o_res = (o_ovf && i_sat_en) ? (ext[W] ? MINV : MAXV) : ext[W-1:0];
endmodule : dsa_lane

//--- hdl/dsa_wmem.sv
// word memory in flip-flops, one write port and nr read ports
`timescale 1ns/100ps
module dsa_wmem #(
  parameter int DW    = 16,
  parameter int DEPTH = 16,
  parameter int NR    = 3,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock
  input  wire logic          i_mclk,
  input  wire logic          i_rstn,
  input  wire logic          i_ce,
  // write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // read ports
  input  wire logic [AW-1:0] i_raddr [NR],
  output logic [DW-1:0]      o_rdata [NR]
);
  logic [DW-1:0] mem_q [DEPTH];

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mem_q <= '{default: '0};
    end else if (i_ce && i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  for (genvar g = 0; g < NR; g++) begin : g_rd
    assign o_rdata[g] = mem_q[i_raddr[g]];
  end
endmodule : dsa_wmem

//--- hdl/dsa_alu.sv
// dual 16-bit subtract/add slice of the 40-bit unit with avalon-mm registers
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "dsa_cfg.svh"
module dsa_alu #(
  parameter int DMEM_DEPTH = 16,
  parameter int NUM_T      = 4,
  parameter int NUM_ACC    = 4
) (
  // clock, reset, enable
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  // avalon-mm slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // status
  output logic [3:0]       o_acc_ovf,
  output logic             o_carry,
  output logic             o_busy
);
  localparam int AW = $clog2(DMEM_DEPTH);

  function automatic dsa_pkg::dsa_op_t dec_op(input logic [23:0] ins);
    logic [7:0] b0;
    logic [3:0] nb;
    b0 = ins[`DSA_F_OPC +: 8];
    nb = ins[`DSA_F_NIB +: 4];
    if (b0 == `DSA_OPC_SHORT && nb == `DSA_NIB_SA16) begin
      dec_op = dsa_pkg::op_sa16;
    end else if (b0 == `DSA_OPC_LONG && nb[3:1] == `DSA_NIB_SA32) begin
      dec_op = dsa_pkg::op_sa32;
    end else if (b0 == `DSA_OPC_LONG && nb == `DSA_NIB_DSUB) begin
      dec_op = dsa_pkg::op_dsub;
    end else begin
      dec_op = dsa_pkg::op_bad;
    end
  endfunction : dec_op

  function automatic logic [23:0] widen(input logic [15:0] v, input logic sx);
    widen = {{8{sx & v[15]}}, v};
  endfunction : widen

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  // bus side
  logic                 wait_q;
  logic [31:0]          rdata_q;
  logic [31:0]          rd_mux;
  logic                 req;
  logic                 wr_ok;
  logic [7:0]           adr;
  logic [31:0]          wd;
  logic [3:0]           be;
  logic                 in_treg;
  logic                 in_acc;
  logic                 in_dmem;
  // software state
  logic [3:0]           ctrl_q;
  logic [7:0]           rpt_cfg_q;
  logic [15:0]          t_q [NUM_T];
  logic [23:0]          instr_q;
  logic [31:0]          ctrl_m;
  logic [31:0]          rpt_m;
  logic [31:0]          t_m;
  logic [31:0]          ins_m;
  logic [31:0]          dm_m;
  // execution
  dsa_pkg::dsa_state_t  state_q;
  logic                 busy_q;
  logic [7:0]           rpt_q;
  dsa_pkg::dsa_acc_t    acc_q [NUM_ACC];
  logic [3:0]           ovf_q;
  logic                 carry_q;
  logic                 bad_q;
  logic                 start_ok;
  logic                 fire;
  dsa_pkg::dsa_op_t     op;
  logic [1:0]           dd;
  logic [1:0]           ss;
  logic [6:0]           maddr;
  logic [15:0]          tv;
  logic [AW-1:0]        hi_idx;
  logic [AW-1:0]        lo_idx;
  logic [AW-1:0]        raddr [3];
  logic [15:0]          rdata [3];
  logic [15:0]          lo_a;
  logic                 lo_sub;
  logic                 hi_cin;
  logic                 sat_en;
  logic [15:0]          lo_res;
  logic [23:0]          hi_res;
  logic                 lo_cout;
  logic                 hi_cout;
  logic                 lo_ovf;
  logic                 hi_ovf;
  logic                 ovf_any;
  logic [3:0]           ovf_clr;
  logic [3:0]           ovf_set;

  assign adr     = i_avs_address;
  assign wd      = i_avs_writedata;
  assign be      = i_avs_byteenable;
  assign req     = i_avs_read || i_avs_write;
  assign wr_ok   = i_avs_write && !wait_q;
  assign in_treg = adr[7:4] == `DSA_REG_TREG;
  assign in_acc  = adr[7:5] == `DSA_REG_ACC;
  assign in_dmem = adr[7:6] == `DSA_REG_DMEM;
  assign ctrl_m  = merge({28'h000_0000, ctrl_q}, wd, be);
  assign rpt_m   = merge({24'h00_0000, rpt_cfg_q}, wd, be);
  assign t_m     = merge({16'h0000, t_q[adr[3:2]]}, wd, be);
  assign ins_m   = merge({8'h00, instr_q}, wd, be);
  assign dm_m    = merge({16'h0000, rdata[2]}, wd, be);
  assign start_ok = wr_ok && adr == `DSA_OFF_INSTR;

  // one wait cycle per access; everything waits while an instruction runs
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_q <= 1'b1;
    end else if (i_ce) begin
      wait_q <= !(req && wait_q && !busy_q);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_ce && i_avs_read && wait_q && !busy_q) begin
      rdata_q <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (adr == `DSA_OFF_CTRL) begin
      rd_mux[3:0] = ctrl_q;
    end else if (adr == `DSA_OFF_STATUS) begin
      rd_mux[6:0] = {bad_q, busy_q, carry_q, ovf_q};
    end else if (adr == `DSA_OFF_INSTR) begin
      rd_mux[23:0] = instr_q;
    end else if (adr == `DSA_OFF_REPEAT) begin
      rd_mux[7:0] = rpt_cfg_q;
    end else if (in_treg) begin
      rd_mux[15:0] = t_q[adr[3:2]];
    end else if (in_acc) begin
      rd_mux = adr[2] ? {24'h00_0000, acc_q[adr[4:3]][39:32]} : acc_q[adr[4:3]][31:0];
    end else if (in_dmem) begin
      rd_mux[15:0] = rdata[2];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q    <= `DSA_CTRL_RST;
      rpt_cfg_q <= `DSA_RPT_RST;
      t_q       <= '{default: '0};
      instr_q   <= 24'h00_0000;
    end else if (i_ce && wr_ok) begin
      if (adr == `DSA_OFF_CTRL) begin
        ctrl_q <= ctrl_m[3:0];
      end
      if (adr == `DSA_OFF_REPEAT) begin
        rpt_cfg_q <= rpt_m[7:0];
      end
      if (in_treg) begin
        t_q[adr[3:2]] <= t_m[15:0];
      end
      if (start_ok) begin
        instr_q <= ins_m[`DSA_INSTR_W-1:0];
      end
    end
  end

  dsa_wmem #(
    .DW    (16),
    .DEPTH (DMEM_DEPTH),
    .NR    (3),
    .AW    (AW)
  ) u_wmem (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_ce    (i_ce),
    .i_we    (wr_ok && in_dmem),
    .i_waddr (adr[AW+1:2]),
    .i_wdata (dm_m[15:0]),
    .i_raddr (raddr),
    .o_rdata (rdata)
  );

  // start, repeat and one result per cycle
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= dsa_pkg::st_idle;
      busy_q  <= 1'b0;
      rpt_q   <= 8'h00;
    end else if (i_ce) begin
      case (state_q)
        dsa_pkg::st_idle: begin
          if (start_ok && dec_op(ins_m[23:0]) != dsa_pkg::op_bad) begin
            state_q <= dsa_pkg::st_run;
            busy_q  <= 1'b1;
            rpt_q   <= rpt_cfg_q;
          end
        end
        dsa_pkg::st_run: begin
          if (rpt_q == 8'h00) begin
            state_q <= dsa_pkg::st_idle;
            busy_q  <= 1'b0;
          end else begin
            rpt_q <= rpt_q - 8'h01;
          end
        end
        default: begin
          state_q <= dsa_pkg::st_idle;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  assign fire  = state_q == dsa_pkg::st_run;
  assign op    = dec_op(instr_q);
  assign dd    = instr_q[`DSA_F_DD +: 2];
  assign ss    = instr_q[`DSA_F_SS +: 2];
  assign maddr = instr_q[`DSA_F_ADDR +: 7];
  assign tv    = t_q[ss];

  // pair partner is the other word of the aligned pair, except in the 16-bit form where it is the same word
  assign hi_idx   = maddr[AW-1:0];
  assign lo_idx   = (op == dsa_pkg::op_sa16) ? hi_idx : (hi_idx ^ {{(AW-1){1'b0}}, 1'b1});
  assign raddr[0] = hi_idx;
  assign raddr[1] = lo_idx;
  assign raddr[2] = adr[AW+1:2];

  assign lo_a   = rdata[1];
  assign lo_sub = op == dsa_pkg::op_dsub;
  // chained borrow only in legacy single-arithmetic subtract
  assign hi_cin = (lo_sub && ctrl_q[`DSA_C_LEG] && !ctrl_q[`DSA_C_SPLIT]) ? lo_cout
                : 1'b1;
  assign sat_en = ctrl_q[`DSA_C_SAT] && !ctrl_q[`DSA_C_LEG];

  dsa_lane #(
    .W (16),
    .P (15)
  ) u_lo (
    .i_a      (lo_a),
    .i_b      (tv),
    .i_sub    (lo_sub),
    .i_cin    (lo_sub),
    .i_sat_en (sat_en),
    .i_ovf_en (!ctrl_q[`DSA_C_LEG]),
    .o_res    (lo_res),
    .o_cout   (lo_cout),
    .o_ovf    (lo_ovf)
  );

  dsa_lane #(
    .W (24),
    .P (15)
  ) u_hi (
    .i_a      (widen(rdata[0], ctrl_q[`DSA_C_SXM])),
    .i_b      (widen(tv, ctrl_q[`DSA_C_SXM])),
    .i_sub    (1'b1),
    .i_cin    (hi_cin),
    .i_sat_en (sat_en),
    .i_ovf_en (1'b1),
    .o_res    (hi_res),
    .o_cout   (hi_cout),
    .o_ovf    (hi_ovf)
  );

  assign ovf_any = lo_ovf || hi_ovf;
  assign ovf_set = (fire && ovf_any) ? 4'(4'h1 << dd) : 4'h0;
  assign ovf_clr = (wr_ok && adr == `DSA_OFF_STATUS && be[0]) ? wd[3:0] : 4'h0;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_q <= '{default: '0};
    end else if (i_ce && fire) begin
      acc_q[dd] <= {hi_res, lo_res};
    end
  end

  // only software clears; a set in the same cycle wins
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ovf_q <= 4'h0;
    end else if (i_ce) begin
      ovf_q <= (ovf_q & ~ovf_clr) | ovf_set;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      carry_q <= 1'b0;
    end else if (i_ce && fire) begin
      carry_q <= hi_cout;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      bad_q <= 1'b0;
    end else if (i_ce) begin
      if (start_ok && dec_op(ins_m[23:0]) == dsa_pkg::op_bad) begin
        bad_q <= 1'b1;
      end else if (ovf_clr != 4'h0 || (ovf_clr == 4'h0 && wr_ok && adr == `DSA_OFF_STATUS
                   && be[0] && wd[`DSA_S_BAD])) begin
        bad_q <= bad_q && !wd[`DSA_S_BAD];
      end
    end
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_acc_ovf         = ovf_q;
  assign o_carry           = carry_q;
  assign o_busy            = busy_q;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_start;
    i_ce && start_ok && dec_op(ins_m[23:0]) != dsa_pkg::op_bad && !busy_q;
  endsequence
  sequence s_run;
    busy_q && rpt_q == $past(rpt_cfg_q);
  endsequence

  property p_start;
    s_start |=> s_run;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_end;
    i_ce && fire && rpt_q == 8'h00 |=> !busy_q && state_q == dsa_pkg::st_idle;
  endproperty
  a_end: assert property (p_end) else $error("run longer than count");

  property p_flag;
    i_ce && fire && ovf_any |=> o_acc_ovf[$past(dd)];
  endproperty
  a_flag: assert property (p_flag) else $error("overflow flag not set");

  property p_sticky;
    i_ce && ovf_clr == 4'h0 |=> (o_acc_ovf & $past(o_acc_ovf)) == $past(o_acc_ovf);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by op");

  property p_carry;
    i_ce && fire |=> o_carry == $past(hi_cout);
  endproperty
  a_carry: assert property (p_carry) else $error("carry not reported");

  property p_sat_lo;
    fire && sat_en && lo_ovf |-> lo_res == `DSA_LO_MAX || lo_res == `DSA_LO_MIN;
  endproperty
  a_sat_lo: assert property (p_sat_lo) else $error("low clamp wrong");

  property p_sat_hi;
    fire && sat_en && hi_ovf |-> hi_res == `DSA_HI_MAX || hi_res == `DSA_HI_MIN;
  endproperty
  a_sat_hi: assert property (p_sat_hi) else $error("high clamp wrong");

  property p_legacy;
    fire && ctrl_q[`DSA_C_LEG] |-> !lo_ovf && !sat_en && ovf_any == hi_ovf;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy overflow wrong");

  property p_split;
    fire && !(lo_sub && ctrl_q[`DSA_C_LEG] && !ctrl_q[`DSA_C_SPLIT]) |-> hi_cin;
  endproperty
  a_split: assert property (p_split) else $error("carry crossed bit 15");

  property p_chain;
    fire && lo_sub && ctrl_q[`DSA_C_LEG] && !ctrl_q[`DSA_C_SPLIT] |-> hi_cin == lo_cout;
  endproperty
  a_chain: assert property (p_chain) else $error("carry not chained");

  property p_align;
    fire && op != dsa_pkg::op_sa16 |-> (hi_idx ^ lo_idx) == {{(AW-1){1'b0}}, 1'b1};
  endproperty
  a_align: assert property (p_align) else $error("word pair misaligned");
endmodule : dsa_alu

//--- verif/dsa_host.sv
// avalon-mm master model of the pipeline side that loads operands and reads results
`timescale 1ns/100ps
module dsa_host (
  // clock
  input  wire logic        i_mclk,
  // slave answer
  input  wire logic        i_waitrequest,
  input  wire logic [31:0] i_readdata,
  // master request
  output logic [7:0]       o_address,
  output logic             o_read,
  output logic             o_write,
  output logic [31:0]      o_writedata,
  output logic [3:0]       o_byteenable
);
  initial begin
    o_address    = 8'h00;
    o_read       = 1'b0;
    o_write      = 1'b0;
    o_writedata  = 32'h0000_0000;
    o_byteenable = 4'hf;
  end

  // wait and read data are taken at the rising edge that ends the access; no cycle limit here,
  // a hung slave is left to the bench watchdog
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      input logic [3:0] be, output logic [31:0] rdata, output logic ok);
    ok    = 1'b0;
    rdata = 32'h0000_0000;
    @(posedge i_mclk);
    o_address    <= addr;
    o_writedata  <= wdata;
    o_byteenable <= be;
    o_write      <= wr;
    o_read       <= !wr;
    while (!ok) begin
      @(posedge i_mclk);
      ok    = (i_waitrequest === 1'b0);
      rdata = i_readdata;
    end
    o_read      <= 1'b0;
    o_write     <= 1'b0;
    // stale data must not look valid once released
    o_writedata <= ~wdata;
  endtask : xfer
endmodule : dsa_host

//--- verif/dual16_sub_add_alu_bench.sv
// self-checking bench of the dual sub/add slice driven over its register bus
`timescale 1ns/100ps
`include "dsa_cfg.svh"
module dual16_sub_add_alu_bench;
  logic        i_mclk;
  logic        i_rstn;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_wdata;
  logic [3:0]  avs_be;
  logic [31:0] avs_rdata;
  logic        avs_wait;
  logic [3:0]  acc_ovf;
  logic        carry;
  logic        busy;
  logic [3:0]  exp_ovf;
  logic        exp_cy;
  int          n_errors;
  int          checks_done;

  dsa_alu DUT (
    .i_mclk            (i_mclk),
    .i_rstn            (i_rstn),
    .i_ce              (1'b1),
    .i_avs_address     (avs_address),
    .i_avs_read        (avs_read),
    .i_avs_write       (avs_write),
    .i_avs_writedata   (avs_wdata),
    .i_avs_byteenable  (avs_be),
    .o_avs_readdata    (avs_rdata),
    .o_avs_waitrequest (avs_wait),
    .o_acc_ovf         (acc_ovf),
    .o_carry           (carry),
    .o_busy            (busy)
  );

  dsa_host u_host (
    .i_mclk        (i_mclk),
    .i_waitrequest (avs_wait),
    .i_readdata    (avs_rdata),
    .o_address     (avs_address),
    .o_read        (avs_read),
    .o_write       (avs_write),
    .o_writedata   (avs_wdata),
    .o_byteenable  (avs_be)
  );

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic test_done();
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_flags(input logic [4:0] got, input logic [4:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t ns: flags 0x%h expected 0x%h", $time, got, exp);
    end
  endtask : check_flags

  task automatic wr_be(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    logic        ok;
    u_host.xfer(1'b1, a, d, be, r, ok);
    check_word({31'h0, ok}, 32'h0000_0001);
  endtask : wr_be

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_be(a, d, 4'hf);
  endtask : wr

  task automatic rd_check(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        ok;
    u_host.xfer(1'b0, a, 32'h0000_0000, 4'hf, r, ok);
    check_word({31'h0, ok}, 32'h0000_0001);
    check_word(r, x);
  endtask : rd_check

  // returns overflow, carry, 24-bit high lane, 16-bit low lane
  function automatic logic [41:0] ref_op(input logic [3:0] nib, input logic [15:0] t, mh, ml,
                                         input logic [3:0] c);
    logic [23:0] eh, et, rh, hi;
    logic [16:0] sl, sc;
    logic [15:0] lo;
    logic        sub, cin, ovh, ovl, sat;
    int          th, tl;
    sub = (nib == 4'hc);
    eh  = c[0] ? {{8{mh[15]}}, mh} : {8'h00, mh};
    et  = c[0] ? {{8{t[15]}}, t} : {8'h00, t};
    sat = c[1] & ~c[2];
    sl  = sub ? {1'b0, ml} + {1'b0, ~t} + 17'h1 : {1'b0, ml} + {1'b0, t};
    tl  = sub ? int'($signed(ml)) - int'($signed(t)) : int'($signed(ml)) + int'($signed(t));
    cin = (sub && c[2] && !c[3]) ? sl[16] : 1'b1;
    rh  = eh + ~et + {23'h0, cin};
    sc  = {1'b0, eh[15:0]} + {1'b0, ~et[15:0]} + {16'h0, cin};
    th  = int'($signed(eh)) - int'($signed(et)) - int'(!cin);
    ovh = th > 32767 || th < -32768;
    ovl = tl > 32767 || tl < -32768;
    hi  = (sat && ovh) ? ((th > 0) ? 24'h00_7fff : 24'hff_8000) : rh;
    lo  = (sat && ovl) ? ((tl > 0) ? 16'h7fff : 16'h8000) : sl[15:0];
    return {ovh | (ovl & ~c[2]), sc[16], hi, lo};
  endfunction : ref_op

  // temp k and destination k; high word at a, low word at a xor 1
  task automatic run_case(input logic [3:0] nib, input logic [3:0] a, input logic [15:0] t, m0,
                          m1, input logic [3:0] c, input logic [1:0] k, input logic [7:0] rep);
    logic [41:0] e;
    int          n;
    e          = ref_op(nib, t, m0, (nib == 4'h9) ? m0 : m1, c);
    exp_ovf[k] = exp_ovf[k] | e[41];
    exp_cy     = e[40];
    wr(`DSA_OFF_CTRL, {28'h0, c});
    wr(8'h10 | {4'h0, k, 2'b00}, {16'h0, t});
    wr(8'h40 | {2'b00, a, 2'b00}, {16'h0, m0});
    wr(8'h40 | {2'b00, a ^ 4'h1, 2'b00}, {16'h0, m1});
    wr(`DSA_OFF_REPEAT, {24'h0, rep});
    wr(`DSA_OFF_INSTR, {8'h00, (nib == 4'h9) ? 8'hde : 8'hee, 3'b000, a, 1'b0, k, k, nib});
    n = 0;
    repeat (12) begin
      @(negedge i_mclk);
      n += int'(busy === 1'b1);
    end
    check_word(32'(n), {24'h0, rep} + 32'h0000_0001);
    rd_check(8'h20 | {3'b000, k, 3'b000}, e[31:0]);
    rd_check(8'h24 | {3'b000, k, 3'b000}, {24'h0, e[39:32]});
    rd_check(`DSA_OFF_STATUS, {27'h0, exp_cy, exp_ovf});
    check_flags({carry, acc_ovf}, {exp_cy, exp_ovf});
  endtask : run_case

  initial begin
    #400000;
    n_errors++;
    test_done();
  end

  initial begin
    n_errors    = 0;
    checks_done = 0;
    exp_ovf     = 4'h0;
    exp_cy      = 1'b0;
    i_rstn      = 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1'b1;
    wr(8'hfc, 32'hffff_ffff);
    rd_check(8'hfc, 32'h0000_0000);
    // only lane 1 of the second write may land
    wr(8'h10, 32'h0000_1234);
    wr_be(8'h10, 32'h0000_ab00, 4'h2);
    rd_check(8'h10, 32'h0000_ab34);
    run_case(4'hc, 4'd2, 16'h0001, 16'h1234, 16'h0005, 4'h0, 2'd0, 8'd0);
    run_case(4'hc, 4'd5, 16'h8000, 16'h7fff, 16'h0000, 4'h3, 2'd1, 8'd0);
    run_case(4'hc, 4'd6, 16'h0001, 16'h0001, 16'h0000, 4'h5, 2'd1, 8'd0);
    run_case(4'hc, 4'd6, 16'h0001, 16'h0001, 16'h0000, 4'hd, 2'd3, 8'd0);
    run_case(4'h9, 4'd8, 16'h4000, 16'h4000, 16'h0000, 4'h3, 2'd0, 8'd0);
    run_case(4'h9, 4'd8, 16'h4000, 16'h4000, 16'h0000, 4'h7, 2'd2, 8'd0);
    run_case(4'he, 4'd10, 16'h0001, 16'h8000, 16'hffff, 4'h2, 2'd2, 8'd0);
    run_case(4'hf, 4'd11, 16'h0002, 16'h8000, 16'h7fff, 4'h9, 2'd3, 8'd0);
    run_case(4'hc, 4'd12, 16'h8000, 16'h7fff, 16'h0000, 4'hf, 2'd2, 8'd2);
    wr(`DSA_OFF_INSTR, {8'h00, 8'hde, 7'h02, 1'b0, 4'h0, 4'h8});
    rd_check(`DSA_OFF_STATUS, {25'h0, 1'b1, 1'b0, exp_cy, exp_ovf});
    wr(`DSA_OFF_STATUS, 32'h0000_004f);
    rd_check(`DSA_OFF_STATUS, {27'h0, exp_cy, 4'h0});
    check_flags({carry, acc_ovf}, {exp_cy, 4'h0});
    test_done();
  end
endmodule : dual16_sub_add_alu_bench
